// ### hw/sdram_cmd_pkg.sv
// Purpose: shared constants and types for the sdram command/address decode link
// Assumes: one clock, synchronous active-high reset
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
package sdram_cmd_pkg;
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 12;
	localparam int BANK_W     = 2;
	localparam int LANES      = 4;
	localparam int COL_W      = 8;
	localparam int AP_BIT     = 10;
	localparam int MASK_LAT   = 2;
	localparam int BANKS      = 4;
	localparam int MEM_DEPTH  = 256;
	localparam int BURST_LEN  = 4;
	localparam logic [1:0] MASK_LAT_M1 = 2'h1;

	typedef enum logic [3:0] {
		CMD_LMR       = 4'h0,
		CMD_REFRESH   = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVE    = 4'h3,
		CMD_WRITE     = 4'h4,
		CMD_READ      = 4'h5,
		CMD_BST       = 4'h6,
		CMD_NOP       = 4'h7,
		CMD_DESELECT  = 4'h8
	} sdram_cmd_t;
endpackage

// ### hw/sdram_link_if.sv
// Purpose: pins between memory controller and sdram device
// Assumes: dq is two-way; each end gives value and output enable
// Notes: resolved bus level is computed here from the enables
`timescale 1ns/10ps
interface sdram_link_if;
	import sdram_cmd_pkg::*;
	logic                     cs_n;
	logic                     ras_n;
	logic                     cas_n;
	logic                     we_n;
	logic [BANK_W-1:0]        bank_select;
	logic [ADDR_W-1:0]        addr;
	logic [LANES-1:0]         byte_lane_mask;
	logic [DATA_W-1:0]        ctl_dq_o;
	logic                     ctl_dq_oe;
	logic [DATA_W-1:0]        dev_dq_o;
	logic [LANES-1:0]         dev_dq_oe;
	logic [DATA_W-1:0]        dq;

	always_comb
	begin
		for (int i = 0; i < LANES; i++)
		begin
			if (ctl_dq_oe)
				dq[i*8 +: 8] = ctl_dq_o[i*8 +: 8];
			else if (dev_dq_oe[i])
				dq[i*8 +: 8] = dev_dq_o[i*8 +: 8];
			else
				dq[i*8 +: 8] = 8'h00;
		end
	end

	modport ctl (output cs_n, ras_n, cas_n, we_n, bank_select, addr, byte_lane_mask,
		ctl_dq_o, ctl_dq_oe, input dq);
	modport dev (input cs_n, ras_n, cas_n, we_n, bank_select, addr, byte_lane_mask,
		output dev_dq_o, dev_dq_oe, input dq);
endinterface

// ### hw/sdram_device_end.sv
// Purpose: sdram device end: registers pins, decodes commands, small data array
// Assumes: fixed read latency of two cycles after command capture, burst of four
// Notes: array is small (per bank 256 columns, row only tracked); enough for tests
`timescale 1ns/10ps
module sdram_device_end
	import sdram_cmd_pkg::*;
(
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_in,
	sdram_link_if.dev                    link,
	output logic [ADDR_W+BANK_W-1:0]     mode_reg_out,
	output logic [BANKS-1:0]             bank_open_out,
	output logic [ADDR_W-1:0]            last_row_out,
	output logic                         auto_pre_out,
	output logic                         busy_out
);
	typedef struct packed {
		logic [3:0]              cmd;
		logic [BANK_W-1:0]       ba;
		logic [ADDR_W-1:0]       a;
		logic [LANES-1:0]        dqm;
		logic [DATA_W-1:0]       dq;
		logic [ADDR_W+BANK_W-1:0] mode;
		logic [BANKS-1:0]        open;
		logic [BANKS*ADDR_W-1:0] rows;
		logic [ADDR_W-1:0]       last_row;
		logic                    ap;
		logic                    rd;
		logic                    wr;
		logic [1:0]              cnt;
		logic [BANK_W-1:0]       bb;
		logic [COL_W-1:0]        col;
		logic [DATA_W-1:0]       rdata;
		logic                    rvalid;
		logic [LANES-1:0]        dqm_d1;
	} dev_state_t;

	dev_state_t state_q;
	dev_state_t state_d;
	logic [DATA_W-1:0] mem_q [BANKS*MEM_DEPTH];
	logic              mem_we;
	logic [9:0]        mem_idx;
	logic [DATA_W-1:0] mem_wdata;

	// capture every pin on the rising edge; nothing reads raw pins
	always_comb
	begin
		state_d = state_q;
		mem_we = 1'b0;
		mem_wdata = '0;
		state_d.cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
		state_d.ba = link.bank_select;
		state_d.a = link.addr;
		state_d.dqm = link.byte_lane_mask;
		state_d.dq = link.dq;
		state_d.dqm_d1 = state_q.dqm;
		mem_idx = {state_q.bb, state_q.col};
		state_d.rvalid = 1'b0;

		// a running burst advances regardless of chip select
		if (state_q.rd || state_q.wr)
		begin
			if (state_q.wr)
			begin
				mem_we = 1'b1;
				for (int i = 0; i < LANES; i++)
				begin
					// masked lane keeps stored byte
					mem_wdata[i*8 +: 8] = state_q.dqm[i] ? mem_q[mem_idx][i*8 +: 8]
						: state_q.dq[i*8 +: 8];
				end
			end
			else
			begin
				state_d.rdata = mem_q[mem_idx];
				state_d.rvalid = 1'b1;
			end
			state_d.col = state_q.col + 8'h01;
			state_d.cnt = state_q.cnt + 2'h1;
			if (state_q.cnt == 2'(BURST_LEN - 1))
			begin
				state_d.rd = 1'b0;
				state_d.wr = 1'b0;
				if (state_q.ap)
					state_d.open[state_q.bb] = 1'b0;
			end
		end

		// cs high decodes as deselect, so no case matches below
		if (!state_q.cmd[3])
		begin
			case (state_q.cmd)
				CMD_LMR:
					state_d.mode = {state_q.ba, state_q.a};
				CMD_ACTIVE:
				begin
					state_d.open[state_q.ba] = 1'b1;
					state_d.rows[state_q.ba*ADDR_W +: ADDR_W] = state_q.a;
					state_d.last_row = state_q.a;
				end
				CMD_PRECHARGE:
				begin
					if (state_q.a[AP_BIT])
						state_d.open = '0;
					else
						state_d.open[state_q.ba] = 1'b0;
				end
				CMD_READ, CMD_WRITE:
				begin
					state_d.bb = state_q.ba;
					state_d.col = state_q.a[COL_W-1:0];
					state_d.ap = state_q.a[AP_BIT];
					state_d.cnt = 2'h0;
					state_d.rd = (state_q.cmd == CMD_READ);
					state_d.wr = (state_q.cmd == CMD_WRITE);
				end
				CMD_BST:
				begin
					state_d.rd = 1'b0;
					state_d.wr = 1'b0;
				end
				default:
				begin
				end
			endcase
		end

		if (rst_in)
		begin
			state_d = '0;
			state_d.cmd = CMD_DESELECT;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		state_q <= state_d;
		if (mem_we)
			mem_q[mem_idx] <= mem_wdata;
	end

	// mask sampled one edge before this beat's launch edge floats the lane
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		assign link.dev_dq_oe[g] = state_q.rvalid && !state_q.dqm_d1[g];
	end
	assign link.dev_dq_o = state_q.rdata;

	assign mode_reg_out  = state_q.mode;
	assign bank_open_out = state_q.open;
	assign last_row_out  = state_q.last_row;
	assign auto_pre_out  = state_q.ap;
	assign busy_out      = state_q.rd || state_q.wr;
endmodule

// ### hw/sdram_ctl_end.sv
// Purpose: controller end: drives one command per request onto the pins
// Assumes: user holds request until accepted; pins change on rising edge
// Notes: write data rides with each beat request; read data returned registered once from dq
`timescale 1ns/10ps
module sdram_ctl_end
	import sdram_cmd_pkg::*;
(
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_in,
	sdram_link_if.ctl                  link,
	input  wire logic                  req_in,
	input  wire logic [3:0]            req_cmd_in,
	input  wire logic [BANK_W-1:0]     req_bank_in,
	input  wire logic [ADDR_W-1:0]     req_addr_in,
	input  wire logic [LANES-1:0]      req_mask_in,
	input  wire logic                  req_dq_oe_in,
	input  wire logic [DATA_W-1:0]     req_wdata_in,
	output logic                       ack_out,
	output logic [DATA_W-1:0]          rdata_out
);
	typedef struct packed {
		logic [3:0]        cmd;
		logic [BANK_W-1:0] ba;
		logic [ADDR_W-1:0] a;
		logic [LANES-1:0]  dqm;
		logic              oe;
		logic [DATA_W-1:0] wd;
		logic [DATA_W-1:0] rd;
	} ctl_state_t;

	ctl_state_t state_q;
	ctl_state_t state_d;

	// a read mask is user timed: issue it two beats ahead of the data
	always_comb
	begin
		state_d = state_q;
		state_d.rd = link.dq;
		if (req_in)
		begin
			state_d.cmd = req_cmd_in;
			state_d.ba = req_bank_in;
			state_d.a = req_addr_in;
			state_d.dqm = req_mask_in;
			state_d.oe = req_dq_oe_in;
			state_d.wd = req_wdata_in;
		end
		else
		begin
			state_d.cmd = CMD_NOP;
			state_d.oe = 1'b0;
		end
		if (rst_in)
		begin
			state_d = '0;
			state_d.cmd = CMD_DESELECT;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		state_q <= state_d;
	end

	assign ack_out = req_in && !rst_in;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = state_q.cmd;
	assign link.bank_select    = state_q.ba;
	assign link.addr           = state_q.a;
	assign link.byte_lane_mask = state_q.dqm;
	assign link.ctl_dq_o       = state_q.wd;
	assign link.ctl_dq_oe      = state_q.oe;
	assign rdata_out           = state_q.rd;
endmodule

// ### tb/sdram_link_chk.sv
// Purpose: pin-level checks on the sdram link
// Assumes: one clock, synchronous high reset
// Notes: cmd is {cs_n, ras_n, cas_n, we_n}
`timescale 1ns/10ps
module sdram_link_chk
	import sdram_cmd_pkg::*;
(
	input wire logic             sys_clk_in,
	input wire logic             rst_in,
	input wire logic             cs_n,
	input wire logic             ras_n,
	input wire logic             cas_n,
	input wire logic             we_n,
	input wire logic [LANES-1:0] byte_lane_mask,
	input wire logic             ctl_dq_oe,
	input wire logic [LANES-1:0] dev_dq_oe
);
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_rd;
		cmd == CMD_READ ##1 byte_lane_mask == 4'h0;
	endsequence
	// deselected cycles still count as quiet beats
	sequence s_quiet;
		byte_lane_mask == 4'h0 && (cs_n || cmd == CMD_NOP);
	endsequence
	a_mask_float: assert property ((dev_dq_oe & $past(byte_lane_mask, 2)) == 4'h0)
		else $error("masked lane still driven");
	a_read_drive: assert property (s_rd |-> ##2 dev_dq_oe == 4'hf)
		else $error("read data not driven");
	a_read_beats: assert property (s_rd ##1 s_quiet [*3] |-> ##2 dev_dq_oe == 4'hf ##1 dev_dq_oe == 4'h0)
		else $error("read burst length wrong");
	a_drive_origin: assert property ($rose(|dev_dq_oe) |-> $past(cmd, 3) == CMD_READ)
		else $error("drive without selected read");
	a_write_quiet: assert property (cmd == CMD_WRITE |-> dev_dq_oe == 4'h0 [*4])
		else $error("device drives during write");
	a_write_ctl: assert property (cmd == CMD_WRITE |-> ctl_dq_oe)
		else $error("write beat not driven");
	a_one_driver: assert property (!(ctl_dq_oe && |dev_dq_oe))
		else $error("both ends drive data");
	a_reset_idle: assert property ($fell(rst_in) |-> cs_n && !ctl_dq_oe && dev_dq_oe == 4'h0)
		else $error("pins not idle after reset");
endmodule

// ### tb/tb_top.sv
// Purpose: end-to-end test of both link ends
// Assumes: one request per clock, effects seen two edges later
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module tb_top;
	import sdram_cmd_pkg::*;
	logic                     sys_clk_in;
	logic                     rst_in;
	logic                     req_in;
	logic [3:0]               req_cmd_in;
	logic [BANK_W-1:0]        req_bank_in;
	logic [ADDR_W-1:0]        req_addr_in;
	logic [LANES-1:0]         req_mask_in;
	logic                     req_dq_oe_in;
	logic [DATA_W-1:0]        req_wdata_in;
	logic                     ack_out;
	logic [DATA_W-1:0]        rdata_out;
	logic [ADDR_W+BANK_W-1:0] mode_reg_out;
	logic [BANKS-1:0]         bank_open_out;
	logic [ADDR_W-1:0]        last_row_out;
	logic                     auto_pre_out;
	logic                     busy_out;
	logic [127:0]             a;
	logic [127:0]             s;
	int                       err_count;
	int                       comparisons;
	int                       cycles;
	sdram_link_if link ();
	sdram_ctl_end u_sdram_ctl_end (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link.ctl),
		.req_in(req_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
		.req_addr_in(req_addr_in), .req_mask_in(req_mask_in), .req_dq_oe_in(req_dq_oe_in),
		.req_wdata_in(req_wdata_in), .ack_out(ack_out), .rdata_out(rdata_out));
	sdram_device_end u_sdram_device_end (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.link(link.dev), .mode_reg_out(mode_reg_out), .bank_open_out(bank_open_out),
		.last_row_out(last_row_out), .auto_pre_out(auto_pre_out), .busy_out(busy_out));
	sdram_link_chk u_sdram_link_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.byte_lane_mask(link.byte_lane_mask), .ctl_dq_oe(link.ctl_dq_oe),
		.dev_dq_oe(link.dev_dq_oe));
	task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic issue(logic [3:0] c, logic [1:0] b, logic [11:0] ad, logic [3:0] m,
		logic oe, logic [31:0] d);
		@(negedge sys_clk_in);
		{req_in, req_cmd_in, req_bank_in, req_addr_in, req_mask_in} = {1'b1, c, b, ad, m};
		{req_dq_oe_in, req_wdata_in} = {oe, d};
		#1;
		chk("ack", 1'b1, ack_out);
		@(posedge sys_clk_in);
	endtask
	task automatic idle(int n);
		@(negedge sys_clk_in);
		req_in = 1'b0;
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic wr(logic [1:0] b, logic [11:0] ad, logic [127:0] d, logic [15:0] m);
		// beat k rides on the pins one cycle after the command plus k
		issue(CMD_WRITE, b, ad, 4'h0, 1'b1, 32'h0);
		for (int k = 0; k < 4; k++)
			issue(CMD_NOP, b, ad, m[4*k +: 4], 1'b1, d[32*k +: 32]);
		idle(4);
	endtask
	// beats ride on deselected cycles so the burst must carry on regardless
	task automatic rd(logic [1:0] b, logic [11:0] ad, logic [127:0] e, logic [15:0] m);
		issue(CMD_READ, b, ad, 4'h0, 1'b0, 32'h0);
		for (int k = 0; k < 4; k++)
			issue(4'hf, b, ad, m[4*k +: 4], 1'b0, 32'h0);
		idle(0);
		for (int k = 0; k < 4; k++)
		begin
			chk("rdata", e[32*k +: 32], rdata_out);
			@(posedge sys_clk_in);
			#1;
		end
	endtask
	function automatic logic [127:0] keep(logic [127:0] x, logic [127:0] y, logic [15:0] m);
		for (int i = 0; i < 16; i++)
			if (m[i])
				x[8*i +: 8] = y[8*i +: 8];
		return x;
	endfunction
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			end_sim();
		end
	end
	initial
	begin
		{req_in, req_cmd_in, req_bank_in, req_addr_in, req_mask_in, req_dq_oe_in} = '0;
		{req_wdata_in, err_count, comparisons, cycles, rst_in} = {96'h0, 1'b1};
		a = 128'h00112233445566778899aabbccddeeff;
		repeat (10) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		rst_in = 1'b0;
		issue(CMD_LMR, 2'h2, 12'ha5c, 4'h0, 1'b0, 32'h0);
		issue(CMD_DESELECT, 2'h1, 12'h3c3, 4'h0, 1'b0, 32'h0);
		idle(2);
		chk("mode", {2'h2, 12'ha5c}, mode_reg_out);
		$display("test mode done");
		issue(CMD_ACTIVE, 2'h1, 12'h123, 4'h0, 1'b0, 32'h0);
		issue(CMD_ACTIVE, 2'h3, 12'h9e7, 4'h0, 1'b0, 32'h0);
		idle(2);
		chk("open", 4'ha, bank_open_out);
		chk("row", 12'h9e7, last_row_out);
		issue(CMD_PRECHARGE, 2'h1, 12'h000, 4'h0, 1'b0, 32'h0);
		idle(2);
		chk("open", 4'h8, bank_open_out);
		issue(CMD_ACTIVE, 2'h0, 12'h001, 4'h0, 1'b0, 32'h0);
		issue(CMD_PRECHARGE, 2'h2, 12'h400, 4'h0, 1'b0, 32'h0);
		idle(2);
		chk("open", 4'h0, bank_open_out);
		$display("test banks done");
		issue(CMD_ACTIVE, 2'h0, 12'h001, 4'h0, 1'b0, 32'h0);
		wr(2'h0, 12'h004, a, 16'h0);
		wr(2'h0, 12'hb04, ~a, 16'h8421);
		s = keep(~a, a, 16'h8421);
		rd(2'h0, 12'h304, s, 16'h0);
		chk("autopre", 1'b0, auto_pre_out);
		rd(2'h0, 12'h404, keep(s, 128'h0, 16'h1248), 16'h1248);
		idle(2);
		chk("autopre", 1'b1, auto_pre_out);
		chk("open", 4'h0, bank_open_out);
		$display("test data done");
		issue(CMD_ACTIVE, 2'h0, 12'h001, 4'h0, 1'b0, 32'h0);
		issue(4'hd, 2'h0, 12'h004, 4'h0, 1'b0, 32'h0);
		idle(4);
		chk("rdata", 32'h0, rdata_out);
		chk("busy", 1'b0, busy_out);
		idle(4);
		$display("test deselect done");
		end_sim();
	end
endmodule
